// >>> rtl/trcr_pkg.sv
// Purpose: Shared constants, types and helpers of the temperature result
//          block and its register-pointer link.
// Assumes: Temperatures arrive in signed quarter-degree units.
// Notes:   Pointer values differ for reads and writes of some registers.
package trcr_pkg;

  // ---------------------------------------------------------------
  // Register pointer values
  // ---------------------------------------------------------------
  localparam logic [7:0] PTR_RD_LOCAL = 8'h00;
  localparam logic [7:0] PTR_RD_REM_INT = 8'h01;
  localparam logic [7:0] PTR_RD_SETUP = 8'h03;
  localparam logic [7:0] PTR_RD_RATE = 8'h04;
  localparam logic [7:0] PTR_WR_SETUP = 8'h09;
  localparam logic [7:0] PTR_WR_RATE = 8'h0A;
  localparam logic [7:0] PTR_RD_REM_FRAC = 8'h10;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Reset values and setup fields
  // ---------------------------------------------------------------
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] SETUP_WMASK = 8'hE4;
  localparam logic [7:0] RATE_RESET = 8'h08;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam int BIT_ALERT_SUPPRESS = 7;
  localparam int BIT_STANDBY = 6;
  localparam int BIT_PIN_FUNCTION = 5;
  localparam int BIT_RANGE = 2;

  // ---------------------------------------------------------------
  // Conversion timing
  // ---------------------------------------------------------------
  localparam logic [3:0] RATE_CODE_MAX = 4'hA;
  localparam int DIV_MAX = 1024;
  localparam int SLOWEST_PERIOD_S = 16;
  localparam int CLK_HZ = 10000000;
  localparam int TICK_CYCLES = SLOWEST_PERIOD_S * CLK_HZ / DIV_MAX;

  // ---------------------------------------------------------------
  // Temperature encoding, in quarter degrees
  // ---------------------------------------------------------------
  localparam logic signed [11:0] EXT_OFFSET_Q = 12'sh100;
  localparam logic signed [11:0] DEF_MAX_Q = 12'sh1FF;
  localparam logic signed [11:0] EXT_MAX_Q = 12'sh3FF;
  localparam logic signed [11:0] ZERO_Q = 12'sh000;

  // ---------------------------------------------------------------
  // Host register map on APB
  // ---------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] HOST_CMD_OFS = 12'h000;
  localparam logic [11:0] HOST_STAT_OFS = 12'h004;
  localparam int CMD_WR_BIT = 16;
  localparam int CMD_LEN2_BIT = 17;
  localparam int STAT_BUSY_BIT = 0;

  typedef enum {CONV_IDLE, CONV_WAIT} trcr_conv_st_t;

  // Turns a quarter-degree value into {integer byte, two fraction bits},
  // offset by 64 degrees in the extended range only, and clamped to the range that is selected.
  function automatic logic [9:0] trcr_encode(input logic signed [10:0] q,
                                             input logic ext);
    logic signed [11:0] v;
    v = 12'(q) + (ext ? EXT_OFFSET_Q : ZERO_Q);
    if (v < ZERO_Q) begin
      v = ZERO_Q;
    end else if (v > (ext ? EXT_MAX_Q : DEF_MAX_Q)) begin
      v = ext ? EXT_MAX_Q : DEF_MAX_Q;
    end
    return v[9:0];
  endfunction

endpackage

// >>> rtl/trcr_if.sv
// Purpose: Register-pointer link between the host end and the device end.
// Assumes: Both ends run on pclk; req is held until ack.
// Notes:   One transfer is a pointer write, a pointer plus data write,
//          or a one-byte read at the current pointer.
`timescale 1ns/100ps
interface trcr_if;
  logic req;
  logic wr;
  logic len2;
  logic [7:0] ptr_byte;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev (input req, input wr, input len2, input ptr_byte,
               input wdata, output ack, output rdata);
  modport host (output req, output wr, output len2, output ptr_byte,
                output wdata, input ack, input rdata);
endinterface

// >>> rtl/trcr_rate_div.sv
// Purpose: Conversion scheduler: a base tick divided by a power of two.
// Assumes: code above the fastest code is treated as the fastest code.
// Notes:   The counters restart while run is low.
`timescale 1ns/100ps
module trcr_rate_div #(
  parameter int TICK_CYCLES = trcr_pkg::TICK_CYCLES
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic run, // High while conversions are wanted.
  input wire logic [3:0] code, // Rate code, low nibble.
  output logic conv_start // One-cycle pulse at each period start.
);
  import trcr_pkg::*;

  logic [31:0] pre_reg;
  logic [10:0] per_reg;
  logic [10:0] per_len;
  logic tick;
  logic [3:0] eff_code;

  assign eff_code = (code > RATE_CODE_MAX) ? RATE_CODE_MAX : code;
  assign per_len = 11'(DIV_MAX >> eff_code); // [R13]
  assign tick = (pre_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
    end else if (!run || tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_reg <= '0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (!run) begin
        per_reg <= '0;
      end else if (tick) begin
        if (per_reg >= per_len - 11'h1) begin
          per_reg <= '0;
          conv_start <= 1'b1; // [R14]
        end else begin
          per_reg <= per_reg + 11'h1;
        end
      end
    end
  end
endmodule

// >>> rtl/trcr_device.sv
// Purpose: Device end: result registers, setup, conversion rate, link slave.
// Assumes: The front end answers each conv_req with one meas_valid pulse.
// Notes:   Limit values arrive already encoded in the active format.
// Notes on behaviour
// [R1] Local result at 0x00, one degree steps.
// [R2] Remote result: integer 0x01, fraction 0x10.
// [R3] Fraction uses top two bits, rest zero.
// [R4] Fraction read freezes integer until integer read.
// [R5] Setup bit 2 selects default or extended range.
// [R6] New range applies from next conversion onward.
// [R7] Shorted remote diode keeps last good result.
// [R8] Default plain binary, extended adds 64 degrees.
// [R9] Setup bit 7 masks the alert output.
// [R10] Setup bit 6 stops conversions in standby.
// [R11] Setup bit 5 picks alert or second overtemp.
// [R12] Rate read at 0x04, written at 0x0A.
// [R13] Rate low nibble divides base tick by 2^n.
// [R14] Code 0x00 is 16 s, each code halves.
// [R15] Each period converts both channels, updates results.
// [R16] Host writes zeros into rate upper nibble; trcr_host forwards the nibble as written, and the device stores it.
// [R17] Rate resets to 0x08, sixteen per second.
// [R18] Host never writes rate codes 0x0B to 0xFF; trcr_host forwards any code, and the divider uses the low nibble only, treating 0xB to 0xF as 0xA.
// [R19] After conversion compare results with channel limits.
// [R20] First write byte loads pointer, second stores.
// [R21] Reads and writes use their own pointer values.
// [R22] Reserved setup bits ignore writes, read zero.
`timescale 1ns/100ps
module trcr_device #(
  parameter int TICK_CYCLES = trcr_pkg::TICK_CYCLES
) (
  input wire logic pclk, // Clock, 10 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  trcr_if.dev link, // Register-pointer link from the host end.
  input wire logic meas_valid, // Pulse: both measurements ready.
  input wire logic signed [8:0] meas_local, // Local, whole degrees.
  input wire logic signed [10:0] meas_remote, // Remote, quarter degrees.
  input wire logic meas_remote_short, // Remote diode seen as shorted.
  input wire logic [7:0] local_high_lim, // Local high limit, encoded.
  input wire logic [7:0] local_low_lim, // Local low limit, encoded.
  input wire logic [7:0] remote_high_lim, // Remote high limit, encoded.
  input wire logic [7:0] remote_low_lim, // Remote low limit, encoded.
  output logic conv_req, // Pulse: convert both channels now.
  output logic range_ext, // Range used for the conversion running.
  output logic out_of_limit, // Last conversion broke a limit.
  output logic shared_pin_o, // Shared open-drain pin, output level.
  output logic shared_pin_oe // Shared open-drain pin, pulls low.
);
  import trcr_pkg::*;

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [7:0] setup_reg;
  logic [7:0] rate_reg;
  logic [7:0] local_reg;
  logic [7:0] rem_int_reg;
  logic [1:0] rem_frac_reg;
  logic lock_reg;
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic over_high_reg;
  trcr_conv_st_t conv_st_reg;
  logic conv_start;
  logic take;
  logic wr_data;
  logic [7:0] rd_val;
  logic [9:0] enc_local;
  logic [9:0] enc_remote;
  logic [7:0] rem_cmp;
  logic viol_next;
  logic high_next;

  assign take = link.req && !ack_reg;
  assign wr_data = take && link.wr && link.len2;
  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;

  // ---------------------------------------------------------------
  // Conversion scheduling
  // ---------------------------------------------------------------
  trcr_rate_div #(.TICK_CYCLES(TICK_CYCLES)) u_rate_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(!setup_reg[BIT_STANDBY]), // [R10]
    .code(rate_reg[3:0]), // [R13]
    .conv_start(conv_start)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_st_reg <= CONV_IDLE;
      conv_req <= 1'b0;
      range_ext <= 1'b0;
    end else begin
      conv_req <= 1'b0;
      case (conv_st_reg)
        CONV_IDLE: begin
          if (conv_start) begin
            conv_req <= 1'b1; // [R15]
            range_ext <= setup_reg[BIT_RANGE]; // [R6]
            conv_st_reg <= CONV_WAIT;
          end
        end
        CONV_WAIT: begin
          if (meas_valid) begin
            conv_st_reg <= CONV_IDLE;
          end
        end
        default: begin
          conv_st_reg <= CONV_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Result encoding and storage
  // ---------------------------------------------------------------
  assign enc_local = trcr_encode({meas_local, 2'b00}, range_ext); // [R5] [R8]
  assign enc_remote = trcr_encode(meas_remote, range_ext); // [R5] [R8]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_reg <= RESULT_RESET;
    end else if (meas_valid && conv_st_reg == CONV_WAIT) begin
      local_reg <= enc_local[9:2]; // [R1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_int_reg <= RESULT_RESET;
      rem_frac_reg <= 2'b00;
    end else if (meas_valid && conv_st_reg == CONV_WAIT &&
                 !meas_remote_short) begin // [R7]
      rem_frac_reg <= enc_remote[1:0]; // [R3]
      if (!lock_reg) begin
        rem_int_reg <= enc_remote[9:2]; // [R2] [R4]
      end
    end
  end

  // The integer byte stays frozen from a fraction read to an integer read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
    end else if (take && !link.wr) begin
      if (ptr_reg == PTR_RD_REM_FRAC) begin
        lock_reg <= 1'b1; // [R4]
      end else if (ptr_reg == PTR_RD_REM_INT) begin
        lock_reg <= 1'b0; // [R4]
      end
    end
  end

  // ---------------------------------------------------------------
  // Limit comparison and shared pin
  // ---------------------------------------------------------------
  assign rem_cmp = meas_remote_short ? rem_int_reg : enc_remote[9:2];
  assign high_next = (enc_local[9:2] > local_high_lim) ||
                     (rem_cmp > remote_high_lim);
  assign viol_next = high_next || (enc_local[9:2] < local_low_lim) ||
                     (rem_cmp < remote_low_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_of_limit <= 1'b0;
      over_high_reg <= 1'b0;
    end else if (meas_valid && conv_st_reg == CONV_WAIT) begin
      out_of_limit <= viol_next; // [R19]
      over_high_reg <= high_next; // [R19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_pin_o <= 1'b0;
      shared_pin_oe <= 1'b0;
    end else if (setup_reg[BIT_PIN_FUNCTION]) begin
      shared_pin_oe <= over_high_reg; // [R11]
    end else begin
      shared_pin_oe <= out_of_limit &&
                       !setup_reg[BIT_ALERT_SUPPRESS]; // [R9] [R11]
    end
  end

  // ---------------------------------------------------------------
  // Link slave: pointer, writes and reads
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= take;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= PTR_RESET;
    end else if (take && link.wr) begin
      ptr_reg <= link.ptr_byte; // [R20]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_reg <= SETUP_RESET;
    end else if (wr_data && link.ptr_byte == PTR_WR_SETUP) begin // [R21]
      setup_reg <= link.wdata & SETUP_WMASK; // [R20] [R22]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg <= RATE_RESET; // [R17]
    end else if (wr_data && link.ptr_byte == PTR_WR_RATE) begin // [R12]
      rate_reg <= link.wdata;
    end
  end

  always_comb begin
    case (ptr_reg)
      PTR_RD_LOCAL: rd_val = local_reg; // [R1]
      PTR_RD_REM_INT: rd_val = rem_int_reg; // [R2]
      PTR_RD_SETUP: rd_val = setup_reg; // [R21]
      PTR_RD_RATE: rd_val = rate_reg; // [R12]
      PTR_RD_REM_FRAC: rd_val = {rem_frac_reg, 6'b000000}; // [R3]
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 8'h00;
    end else if (take && !link.wr) begin
      rdata_reg <= rd_val;
    end
  end
endmodule

// >>> rtl/trcr_host.sv
// Purpose: Host end: APB registers that start link transfers.
// Assumes: Software writes one command and waits for busy to clear.
// Notes:   A command written while busy is dropped.
`timescale 1ns/100ps
module trcr_host (
  input wire logic pclk, // Clock, 10 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [trcr_pkg::APB_AW-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, unmapped address.
  trcr_if.host link // Register-pointer link to the device end.
);
  import trcr_pkg::*;

  logic busy_reg;
  logic [7:0] last_rd_reg;
  logic req_reg;
  logic wr_reg;
  logic len2_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wdata_reg;
  logic setup;
  logic start;
  logic mapped;

  assign link.req = req_reg;
  assign link.wr = wr_reg;
  assign link.len2 = len2_reg;
  assign link.ptr_byte = ptr_reg;
  assign link.wdata = wdata_reg;

  assign setup = psel && !penable && !pready;
  assign mapped = (paddr == HOST_CMD_OFS) || (paddr == HOST_STAT_OFS);
  assign start = psel && penable && pready && pwrite &&
                 paddr == HOST_CMD_OFS && !busy_reg;

  // ---------------------------------------------------------------
  // APB slave, one wait-free access cycle
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite && paddr == HOST_STAT_OFS) begin
        prdata <= {16'h0000, last_rd_reg, 7'h00, busy_reg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Link master
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      len2_reg <= 1'b0;
      ptr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (start) begin
      busy_reg <= 1'b1;
      req_reg <= 1'b1;
      wr_reg <= pwdata[CMD_WR_BIT];
      len2_reg <= pwdata[CMD_LEN2_BIT] && pwdata[CMD_WR_BIT]; // [R20]
      ptr_reg <= pwdata[7:0]; // [R21]
      wdata_reg <= pwdata[15:8]; // [R16] [R18]
    end else if (req_reg && link.ack) begin
      busy_reg <= 1'b0;
      req_reg <= 1'b0;
    end
  end

  // Read data of the last read; software reads fraction then integer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rd_reg <= 8'h00;
    end else if (req_reg && link.ack && !wr_reg) begin
      last_rd_reg <= link.rdata; // [R4] [R12]
    end
  end
endmodule

// >>> dv/trcr_assertions.sv
// Purpose: Link checks between the host end and the device end.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Sees only the trcr_if signals.
`timescale 1ns/100ps
module trcr_assertions
  import trcr_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic req, // Transfer pending.
  input wire logic wr, // Write transfer.
  input wire logic len2, // Write carries data.
  input wire logic [7:0] ptr_byte, // Pointer byte.
  input wire logic [7:0] wdata, // Data byte.
  input wire logic ack, // Transfer done.
  input wire logic [7:0] rdata // Read byte.
);
  // ----------------------------------------------------------------
  // Pointer mirror and checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] ptr_reg;
  logic rd_ack;
  assign rd_ack = ack && !wr;
  // Follows the device pointer so reads can be judged by target.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= PTR_RESET;
    end else if (ack && wr) begin
      ptr_reg <= ptr_byte;
    end
  end
  AST_ACK_ONE_LATER: assert property (req && !ack |=> ack)
    else $error("ack not one cycle after request");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_REQ_RELEASE: assert property (ack |=> !req)
    else $error("request not released after ack");
  AST_REQ_HOLD: assert property (
    req && !ack |=> $stable({wr, len2, ptr_byte, wdata}))
    else $error("request changed before ack");
  AST_RDATA_ON_READ: assert property (!$stable(rdata) |-> rd_ack)
    else $error("read byte changed outside a read");
  AST_FRAC_LOW_ZERO: assert property (
    rd_ack && ptr_reg == PTR_RD_REM_FRAC |-> rdata[5:0] == 6'h00)
    else $error("fraction low bits not zero");
  AST_SETUP_RSVD_ZERO: assert property (
    rd_ack && ptr_reg == PTR_RD_SETUP |-> (rdata & ~SETUP_WMASK) == 8'h00)
    else $error("reserved setup bits not zero");
  AST_WR_PTR_READ_ZERO: assert property (
    rd_ack && (ptr_reg == PTR_WR_RATE || ptr_reg == PTR_WR_SETUP)
    |-> rdata == 8'h00)
    else $error("read at a write pointer not zero");
  AST_RATE_CODE_LEGAL: assert property (
    req && wr && len2 && ptr_byte == PTR_WR_RATE |-> wdata <= 8'h0A)
    else $error("reserved rate code written");
  cover property (rd_ack && ptr_reg == PTR_RD_REM_FRAC);
  cover property (ack && wr && len2);
  cover property (rd_ack && ptr_reg == PTR_WR_RATE);
endmodule

// >>> dv/temp_result_config_rate_test.sv
// Purpose: Drives the host end over APB and the device front end.
// Assumes: TICK_CYCLES is shrunk to 4 to keep periods short.
// Notes:   The front end answers each conversion one cycle later.
`timescale 1ns/100ps
module temp_result_config_rate_test;
  import trcr_pkg::*;
  localparam int TICK = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic meas_valid = 1'b0;
  logic meas_remote_short;
  logic signed [8:0] meas_local;
  logic signed [10:0] meas_remote;
  logic [7:0] local_high_lim, local_low_lim, r;
  logic [7:0] remote_high_lim, remote_low_lim;
  logic conv_req, range_ext, out_of_limit, shared_pin_o, shared_pin_oe;
  int num_errors = 0;
  int checks_done = 0;
  int conv_cnt = 0;
  int n;
  trcr_if u_trcr_if ();
  trcr_host u_trcr_host (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(u_trcr_if));
  trcr_device #(.TICK_CYCLES(TICK)) u_trcr_device (.pclk, .presetn,
    .link(u_trcr_if), .meas_valid, .meas_local, .meas_remote,
    .meas_remote_short, .local_high_lim, .local_low_lim,
    .remote_high_lim, .remote_low_lim, .conv_req, .range_ext,
    .out_of_limit, .shared_pin_o, .shared_pin_oe);
  trcr_assertions u_trcr_assertions (.pclk, .presetn,
    .req(u_trcr_if.req), .wr(u_trcr_if.wr), .len2(u_trcr_if.len2),
    .ptr_byte(u_trcr_if.ptr_byte), .wdata(u_trcr_if.wdata),
    .ack(u_trcr_if.ack), .rdata(u_trcr_if.rdata));
  // ----------------------------------------------------------------
  // Clock, front end and bus tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    meas_valid <= (conv_req === 1'b1);
    if (conv_req === 1'b1) begin
      conv_cnt <= conv_cnt + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Issues one link transfer and waits for busy to clear.
  task automatic lk(input logic w, l, input logic [7:0] p, v);
    apb(1'b1, HOST_CMD_OFS, {14'h0, l, w, v, p});
    do begin
      apb(1'b0, HOST_STAT_OFS, 32'h0);
    end while (d[STAT_BUSY_BIT] !== 1'b0);
    r = d[15:8];
  endtask
  task automatic wreg(input logic [7:0] p, v);
    lk(1'b1, 1'b1, p, v);
  endtask
  task automatic rd(input logic [7:0] p, x, input string nm);
    lk(1'b1, 1'b0, p, 8'h00);
    lk(1'b0, 1'b0, 8'h00, 8'h00);
    chk(nm, x, r);
  endtask
  // Cycles between two conversion requests.
  task automatic per(output int c);
    int k;
    k = 0;
    while (conv_req !== 1'b1 && k < 9000) begin
      @(posedge pclk);
      k++;
    end
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (conv_req !== 1'b1 && c < 9000);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {meas_remote_short, meas_local, meas_remote} = '0;
    {local_high_lim, remote_high_lim} = 16'hFFFF;
    {local_low_lim, remote_low_lim} = 16'h0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(PTR_RD_SETUP, SETUP_RESET, "setup");
    rd(PTR_RD_RATE, RATE_RESET, "rate");
    apb(1'b0, 12'h008, 32'h0);
    chk("pslverr", 1, e);
    wreg(PTR_WR_SETUP, 8'hFF);
    rd(PTR_RD_SETUP, 8'hE4, "setup");
    n = conv_cnt;
    repeat (300) @(posedge pclk);
    chk("standby", n, conv_cnt);
    rd(PTR_WR_SETUP, 8'h00, "wr_ptr");
    wreg(PTR_WR_SETUP, 8'h00);
    for (int c = 0; c <= 10; c++) begin
      wreg(PTR_WR_RATE, 8'(c));
      per(n);
      chk("period", TICK * (1024 >> c), n);
    end
    rd(PTR_RD_RATE, 8'h0A, "rate");
    rd(PTR_WR_RATE, 8'h00, "wr_ptr");
    meas_local <= 9'sd25;
    meas_remote <= 11'sd103;
    repeat (12) @(posedge pclk);
    rd(PTR_RD_REM_FRAC, 8'hC0, "frac");
    meas_remote <= 11'sd40;
    repeat (12) @(posedge pclk);
    rd(PTR_RD_REM_INT, 8'h19, "locked");
    rd(PTR_RD_REM_INT, 8'h0A, "unlocked");
    rd(PTR_RD_LOCAL, 8'h19, "local");
    meas_local <= -9'sd5;
    meas_remote <= 11'sd1000;
    repeat (12) @(posedge pclk);
    rd(PTR_RD_REM_FRAC, 8'hC0, "frac");
    rd(PTR_RD_REM_INT, 8'h7F, "int");
    rd(PTR_RD_LOCAL, 8'h00, "local");
    wreg(PTR_WR_SETUP, 8'h04);
    meas_remote <= -11'sd42;
    repeat (12) @(posedge pclk);
    chk("range_ext", 1, range_ext);
    rd(PTR_RD_REM_FRAC, 8'h80, "frac");
    rd(PTR_RD_REM_INT, 8'h35, "int");
    rd(PTR_RD_LOCAL, 8'h3B, "local");
    meas_remote_short <= 1'b1;
    meas_remote <= 11'sd0;
    repeat (12) @(posedge pclk);
    rd(PTR_RD_REM_FRAC, 8'h80, "frac");
    rd(PTR_RD_REM_INT, 8'h35, "int");
    meas_remote_short <= 1'b0;
    local_high_lim <= 8'h30;
    repeat (12) @(posedge pclk);
    chk("out_of_limit", 1, out_of_limit);
    chk("pin_oe", 1, shared_pin_oe);
    wreg(PTR_WR_SETUP, 8'h84);
    chk("pin_oe", 0, shared_pin_oe);
    wreg(PTR_WR_SETUP, 8'hA4);
    chk("pin_oe", 1, shared_pin_oe);
    local_high_lim <= 8'hFF;
    repeat (12) @(posedge pclk);
    chk("out_of_limit", 0, out_of_limit);
    chk("pin_oe", 0, shared_pin_oe);
    remote_low_lim <= 8'h50;
    repeat (12) @(posedge pclk);
    chk("out_of_limit", 1, out_of_limit);
    chk("pin_oe", 0, shared_pin_oe);
    chk("pin_o", 0, shared_pin_o);
    tally_and_finish();
  end
endmodule
